// >>> verilog/cilt_pkg.sv
/*
 * constants, enumerations, carrier structs and shared helpers of the
 * camera io line and pulse timer block.
 * assumes a 125 MHz system clock and a classic wishbone bus of 32 bits.
 */
package cilt_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS  = 8;
	localparam int TICK_PERIOD_NS = 1000;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICK_W         = 7;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	// ----------------------------------------
	// widths, limits and reset values
	// ----------------------------------------
	localparam int NUM_OUT = 6;
	localparam int SEL_W   = 3;
	localparam int FILT_W  = 20;
	localparam int PULSE_W = 27;
	localparam int ADR_W   = 8;
	localparam logic [SEL_W-1:0]   SEL_MAX   = 3'h6;
	localparam logic [SEL_W-1:0]   SEL_RST   = 3'h0;
	localparam logic [FILT_W-1:0]  FILT_MAX  = 20'hF4240;
	localparam logic [FILT_W-1:0]  FILT_RST  = 20'h00000;
	localparam logic [PULSE_W-1:0] PULSE_MAX = 27'h51EB850;
	localparam logic [PULSE_W-1:0] WIDTH_MIN = 27'h0000001;
	localparam logic [PULSE_W-1:0] WIDTH_RST = 27'h0000001;
	localparam logic [PULSE_W-1:0] DELAY_RST = 27'h0000000;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [ADR_W-1:0] OFS_LINE_SEL = 8'h00;
	localparam logic [ADR_W-1:0] OFS_LINE_CFG = 8'h04;
	localparam logic [ADR_W-1:0] OFS_SOFT     = 8'h08;
	localparam logic [ADR_W-1:0] OFS_FILT     = 8'h0C;
	localparam logic [ADR_W-1:0] OFS_WIDTH    = 8'h10;
	localparam logic [ADR_W-1:0] OFS_DELAY    = 8'h14;
	localparam logic [ADR_W-1:0] OFS_TRIG     = 8'h18;
	localparam logic [ADR_W-1:0] OFS_CMD      = 8'h1C;
	localparam logic [ADR_W-1:0] OFS_STATUS   = 8'h20;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int DIR_BIT     = 8;
	localparam int INV_BIT     = 4;
	localparam int COND_LSB    = 4;
	localparam int RESTART_BIT = 0;
	localparam int ST_FILT     = 0;
	localparam int ST_TIMER    = 1;
	localparam int ST_RAW      = 2;
	localparam int ST_LINES    = 8;

	// ----------------------------------------
	// modes and carriers
	// ----------------------------------------
	typedef enum logic [2:0] {
		SRC_OFF, SRC_FRAME, SRC_ROW, SRC_EXPO, SRC_SOFT, SRC_TIMER, SRC_COUNTER
	} cilt_out_src_t;
	typedef enum logic [2:0] {
		TRG_OFF, TRG_EXPO, TRG_FRAME, TRG_LINE, TRG_COUNTER
	} cilt_trig_src_t;
	typedef enum logic [1:0] {CND_RISE, CND_FALL, CND_HIGH, CND_LOW} cilt_trig_cond_t;

	typedef struct packed {
		logic          invert;
		cilt_out_src_t src;
	} cilt_line_cfg_t;

	typedef struct packed {
		cilt_trig_cond_t    cond;
		logic [PULSE_W-1:0] delay;
		logic [PULSE_W-1:0] width;
	} cilt_pulse_cfg_t;

	typedef struct packed {
		logic frame;
		logic row;
		logic expo;
		logic cnt_out;
		logic cnt_begin;
	} cilt_flags_t;

	// merge write data into the old word lane by lane
	function automatic logic [31:0] cilt_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] sel);
		logic [31:0] r;
		r = old_w;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

// >>> verilog/cilt_debounce.sv
/*
 * input filter for the trigger input line.
 * assumes a one-cycle tick every microsecond and a synchronous raw input.
 */
module cilt_debounce
	import cilt_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              tick_i,
	input  wire logic              raw_i,
	input  wire logic [FILT_W-1:0] time_i,
	output logic                   level_o
);
	logic [FILT_W-1:0] cnt_reg;
	logic              level_reg;

	// ----------------------------------------
	// stability counter
	// ----------------------------------------
	// any return to the accepted level drops the count, so short pulses vanish;
	// one tick beyond the setting is counted, as the first tick may come at once
	always_ff @(posedge clk_i) begin
		if (rst_i || raw_i == level_reg) begin
			cnt_reg <= '0;
		end else if (tick_i && cnt_reg <= time_i) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// accept a new level once it has held for the programmed time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_reg <= 1'b0;
		end else if (raw_i != level_reg && (time_i == '0 || cnt_reg > time_i)) begin
			level_reg <= raw_i;
		end
	end

	assign level_o = level_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_change_cause;
		$changed(level_reg) |-> $past(raw_i) == level_reg
			&& ($past(time_i) == '0 || $past(cnt_reg) > $past(time_i));
	endproperty
	a_change_cause: assert property (p_change_cause) else $error("filter level changed early");

	property p_zero_time;
		(time_i == '0 && raw_i != level_reg) |=> level_reg == $past(raw_i);
	endproperty
	a_zero_time: assert property (p_zero_time) else $error("zero filter time not immediate");

endmodule

// >>> verilog/cilt_pulse_timer.sv
/*
 * trigger-driven pulse timer with delay and duration.
 * assumes a microsecond tick and a trigger level already selected upstream.
 */
module cilt_pulse_timer
	import cilt_pkg::*;
(
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            tick_i,
	input  wire logic            restart_i,
	input  wire logic            enable_i,
	input  wire logic            src_i,
	input  cilt_pkg::cilt_pulse_cfg_t cfg_i,
	output logic                 out_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_ACTIVE} cilt_tstate_t;

	cilt_tstate_t       state_reg;
	logic [PULSE_W-1:0] cnt_reg;
	logic               src_reg;
	logic               lvl_mode;
	logic               lvl_ok;
	logic               edge_hit;

	// ----------------------------------------
	// trigger qualification
	// ----------------------------------------
	assign lvl_mode = cfg_i.cond == CND_HIGH || cfg_i.cond == CND_LOW;
	assign lvl_ok   = enable_i && (src_i == (cfg_i.cond == CND_HIGH));
	assign edge_hit = enable_i && src_reg != src_i
		&& src_i == (cfg_i.cond == CND_RISE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_reg <= 1'b0;
		end else begin
			src_reg <= src_i;
		end
	end

	// ----------------------------------------
	// delay then duration sequencer
	// ----------------------------------------
	// a level trigger lost during delay or pulse always aborts to idle
	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					cnt_reg <= '0;
					if (lvl_mode ? lvl_ok : edge_hit) begin
						state_reg <= ST_DELAY;
					end
				end
				ST_DELAY: begin
					if (lvl_mode && !lvl_ok) begin
						state_reg <= ST_IDLE;
					end else if (cnt_reg >= cfg_i.delay) begin
						state_reg <= ST_ACTIVE;
						cnt_reg   <= '0;
					end else if (tick_i) begin
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
				ST_ACTIVE: begin
					if (lvl_mode) begin
						if (!lvl_ok) begin
							state_reg <= ST_IDLE;
						end
					end else if (cnt_reg >= cfg_i.width) begin
						state_reg <= ST_IDLE;
					end else if (tick_i) begin
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	assign out_o = state_reg == ST_ACTIVE;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_restart;
		restart_i |=> !out_o ##1 !out_o || $past(lvl_mode ? lvl_ok : edge_hit);
	endproperty
	a_restart: assert property (p_restart) else $error("restart did not clear timer");

	property p_level_hold;
		(out_o && lvl_mode) |-> $past(lvl_ok);
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("level pulse without source");

	property p_zero_delay;
		(state_reg == ST_DELAY && cfg_i.delay == '0 && !lvl_mode && !restart_i) |=> out_o;
	endproperty
	a_zero_delay: assert property (p_zero_delay) else $error("zero delay not honoured");

endmodule

// >>> verilog/cilt_camera_io.sv
/*
 * camera control io: one filtered trigger input, six output lines with
 * source select and inversion, and a pulse timer, all set over wishbone.
 * assumes frame, row, exposure and counter flags come synchronous from
 * other camera blocks, and a 125 MHz clock with synchronous reset.
 */
// Contract
// - line zero is input only and reports input direction when selected.
// - lines one to six are output only and report output direction.
// - each output line inverts its level when its invert bit is set.
// - output source is off, frame, row, exposure, soft level, timer or counter.
// - exposure flag is high from exposure start to exposure end.
// - soft level source drives low for false and high for true.
// - input filter accepts a level only after it held for the filter time.
// - filtered input changes after the filter time from a valid level.
// - filter time is programmable from zero to one million microseconds.
// - timer source drives the output line from the timer output.
// - timer trigger is off, exposure, frame, filtered input or counter begin.
// - edge modes start the timer on the selected edge of the trigger.
// - level modes keep timer output only while the trigger holds its level.
// - in edge modes the pulse lasts the width, one to 85,899,344 us.
// - the timer waits the delay, zero to 85,899,344 us, before output.
// - a timer restart command clears the running timer.
// - level high starts the delay on source high, then follows the source.
module cilt_camera_io
	import cilt_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               cyc_i,
	input  wire logic               stb_i,
	input  wire logic               we_i,
	input  wire logic [ADR_W-1:0]   adr_i,
	input  wire logic [3:0]         sel_i,
	input  wire logic [31:0]        dat_i,
	output logic      [31:0]        dat_o,
	output logic                    ack_o,
	input  wire logic               trigger_input_line_i,
	input  cilt_pkg::cilt_flags_t   flags_i,
	output logic      [NUM_OUT-1:0] line_o
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [TICK_W-1:0]  tick_cnt_reg;
	logic               tick;
	logic               ack_reg;
	logic [31:0]        dat_reg;
	logic [31:0]        rd_next;
	logic [31:0]        wdat;
	logic               req;
	logic               wr_en;
	logic [SEL_W-1:0]   io_line_select_reg;
	cilt_line_cfg_t     line_cfg_reg [NUM_OUT];
	logic               soft_level_value_reg;
	logic [FILT_W-1:0]  input_filter_time_reg;
	logic [PULSE_W-1:0] pulse_width_reg;
	logic [PULSE_W-1:0] pulse_delay_reg;
	cilt_trig_src_t     pulse_trigger_source_reg;
	cilt_trig_cond_t    pulse_trigger_condition_reg;
	logic               pulse_timer_restart_reg;
	logic               io_direction;
	logic               filtered_level;
	logic               timer_zero_out;
	logic               trig_level;
	logic [NUM_OUT-1:0] drive;
	logic [NUM_OUT-1:0] line_reg;
	cilt_pulse_cfg_t    pulse_cfg;

	// true for the six output-only lines
	function automatic logic is_out_line(input logic [SEL_W-1:0] s);
		return s != SEL_RST && s <= SEL_MAX;
	endfunction

	// index into the output config array for a selected line
	function automatic int out_index(input logic [SEL_W-1:0] s);
		return int'(s) - 1;
	endfunction

	// ----------------------------------------
	// microsecond timebase
	// ----------------------------------------
	// one free running divider shared by filter and timer keeps them in step
	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
		end
	end
	assign tick = tick_cnt_reg == TICK_LAST;

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	// answer one cycle after the request; writes land on the acked edge
	assign req   = cyc_i && stb_i && !ack_reg;
	assign wr_en = cyc_i && stb_i && we_i && ack_reg;
	assign wdat  = cilt_merge(dat_reg, dat_i, sel_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req;
		end
	end

	// read data captured at the request edge, held through the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= '0;
		end else if (req) begin
			dat_reg <= rd_next;
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	// unmapped offsets still ack and read as zero
	always_comb begin
		rd_next = '0;
		if (adr_i == OFS_LINE_SEL) begin
			rd_next[SEL_W-1:0] = io_line_select_reg;
			rd_next[DIR_BIT]   = io_direction;
		end else if (adr_i == OFS_LINE_CFG) begin
			if (is_out_line(io_line_select_reg)) begin
				rd_next[SEL_W-1:0] = line_cfg_reg[out_index(io_line_select_reg)].src;
				rd_next[INV_BIT]   = line_cfg_reg[out_index(io_line_select_reg)].invert;
			end
		end else if (adr_i == OFS_SOFT) begin
			rd_next[0] = soft_level_value_reg;
		end else if (adr_i == OFS_FILT) begin
			rd_next[FILT_W-1:0] = input_filter_time_reg;
		end else if (adr_i == OFS_WIDTH) begin
			rd_next[PULSE_W-1:0] = pulse_width_reg;
		end else if (adr_i == OFS_DELAY) begin
			rd_next[PULSE_W-1:0] = pulse_delay_reg;
		end else if (adr_i == OFS_TRIG) begin
			rd_next[SEL_W-1:0]        = pulse_trigger_source_reg;
			rd_next[COND_LSB +: 2]    = pulse_trigger_condition_reg;
		end else if (adr_i == OFS_STATUS) begin
			rd_next[ST_FILT]               = filtered_level;
			rd_next[ST_TIMER]              = timer_zero_out;
			rd_next[ST_RAW]                = trigger_input_line_i;
			rd_next[ST_LINES +: NUM_OUT]   = line_reg;
		end
	end

	// line zero is the input, every other legal line an output
	assign io_direction = is_out_line(io_line_select_reg);

	// ----------------------------------------
	// line selection and per-line setup
	// ----------------------------------------
	// out of range line numbers are dropped so the selector stays legal
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			io_line_select_reg <= SEL_RST;
		end else if (wr_en && adr_i == OFS_LINE_SEL && wdat[SEL_W-1:0] <= SEL_MAX) begin
			io_line_select_reg <= wdat[SEL_W-1:0];
		end
	end

	// writes to the setup of the input line have nothing to land on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_OUT; i++) begin
				line_cfg_reg[i] <= '{invert: 1'b0, src: SRC_OFF};
			end
		end else if (wr_en && adr_i == OFS_LINE_CFG && is_out_line(io_line_select_reg)) begin
			if (wdat[SEL_W-1:0] <= SRC_COUNTER) begin
				line_cfg_reg[out_index(io_line_select_reg)].src <=
					cilt_out_src_t'(wdat[SEL_W-1:0]);
			end
			line_cfg_reg[out_index(io_line_select_reg)].invert <= wdat[INV_BIT];
		end
	end

	// single soft level, selected implicitly as the only choice
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			soft_level_value_reg <= 1'b0;
		end else if (wr_en && adr_i == OFS_SOFT) begin
			soft_level_value_reg <= wdat[0];
		end
	end

	// ----------------------------------------
	// filter and timer settings
	// ----------------------------------------
	// oversized values saturate rather than wrap to a short time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			input_filter_time_reg <= FILT_RST;
		end else if (wr_en && adr_i == OFS_FILT) begin
			if (wdat[31:FILT_W] != '0 || wdat[FILT_W-1:0] > FILT_MAX) begin
				input_filter_time_reg <= FILT_MAX;
			end else begin
				input_filter_time_reg <= wdat[FILT_W-1:0];
			end
		end
	end

	// width zero is raised to the least legal pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pulse_width_reg <= WIDTH_RST;
		end else if (wr_en && adr_i == OFS_WIDTH) begin
			if (wdat[31:PULSE_W] != '0 || wdat[PULSE_W-1:0] > PULSE_MAX) begin
				pulse_width_reg <= PULSE_MAX;
			end else if (wdat[PULSE_W-1:0] < WIDTH_MIN) begin
				pulse_width_reg <= WIDTH_MIN;
			end else begin
				pulse_width_reg <= wdat[PULSE_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pulse_delay_reg <= DELAY_RST;
		end else if (wr_en && adr_i == OFS_DELAY) begin
			if (wdat[31:PULSE_W] != '0 || wdat[PULSE_W-1:0] > PULSE_MAX) begin
				pulse_delay_reg <= PULSE_MAX;
			end else begin
				pulse_delay_reg <= wdat[PULSE_W-1:0];
			end
		end
	end

	// unknown trigger codes leave the old source in place
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pulse_trigger_source_reg    <= TRG_OFF;
			pulse_trigger_condition_reg <= CND_RISE;
		end else if (wr_en && adr_i == OFS_TRIG) begin
			if (wdat[SEL_W-1:0] <= TRG_COUNTER) begin
				pulse_trigger_source_reg <= cilt_trig_src_t'(wdat[SEL_W-1:0]);
			end
			pulse_trigger_condition_reg <= cilt_trig_cond_t'(wdat[COND_LSB +: 2]);
		end
	end

	// restart is a self-clearing command pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pulse_timer_restart_reg <= 1'b0;
		end else begin
			pulse_timer_restart_reg <= wr_en && adr_i == OFS_CMD && wdat[RESTART_BIT];
		end
	end

	// ----------------------------------------
	// input filter and pulse timer
	// ----------------------------------------
	cilt_debounce u_filter (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.tick_i  (tick),
		.raw_i   (trigger_input_line_i),
		.time_i  (input_filter_time_reg),
		.level_o (filtered_level)
	);

	// trigger source mux; flags arrive already synchronous
	always_comb begin
		case (pulse_trigger_source_reg)
			TRG_EXPO:    trig_level = flags_i.expo;
			TRG_FRAME:   trig_level = flags_i.frame;
			TRG_LINE:    trig_level = filtered_level;
			TRG_COUNTER: trig_level = flags_i.cnt_begin;
			default:     trig_level = 1'b0;
		endcase
	end

	assign pulse_cfg = '{cond: pulse_trigger_condition_reg,
		delay: pulse_delay_reg, width: pulse_width_reg};

	cilt_pulse_timer u_timer (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.tick_i    (tick),
		.restart_i (pulse_timer_restart_reg),
		.enable_i  (pulse_trigger_source_reg != TRG_OFF),
		.src_i     (trig_level),
		.cfg_i     (pulse_cfg),
		.out_o     (timer_zero_out)
	);

	// ----------------------------------------
	// output lines
	// ----------------------------------------
	// outputs are registered so the pins never glitch on a source change
	for (genvar g = 0; g < NUM_OUT; g++) begin : g_line
		always_comb begin
			case (line_cfg_reg[g].src)
				SRC_FRAME:   drive[g] = flags_i.frame;
				SRC_ROW:     drive[g] = flags_i.row;
				SRC_EXPO:    drive[g] = flags_i.expo;
				SRC_SOFT:    drive[g] = soft_level_value_reg;
				SRC_TIMER:   drive[g] = timer_zero_out;
				SRC_COUNTER: drive[g] = flags_i.cnt_out;
				default:     drive[g] = 1'b0;
			endcase
		end

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				line_reg[g] <= 1'b0;
			end else begin
				line_reg[g] <= drive[g] ^ line_cfg_reg[g].invert;
			end
		end
	end

	assign line_o = line_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_dir_read;
		(req && adr_i == OFS_LINE_SEL) |=> ack_o
			&& dat_o[DIR_BIT] == (dat_o[SEL_W-1:0] != SEL_RST);
	endproperty
	a_dir_read: assert property (p_dir_read) else $error("direction reads wrong");

	property p_soft;
		(line_cfg_reg[0].src == SRC_SOFT && !line_cfg_reg[0].invert) |=>
			line_o[0] == $past(soft_level_value_reg);
	endproperty
	a_soft: assert property (p_soft) else $error("soft level not driven");

	property p_invert_off;
		(line_cfg_reg[1].src == SRC_OFF) |=> line_o[1] == $past(line_cfg_reg[1].invert);
	endproperty
	a_invert_off: assert property (p_invert_off) else $error("inversion wrong");

	property p_timer_line;
		(line_cfg_reg[2].src == SRC_TIMER) |=>
			line_o[2] == ($past(timer_zero_out) ^ $past(line_cfg_reg[2].invert));
	endproperty
	a_timer_line: assert property (p_timer_line) else $error("timer not on line");

	property p_expo_line;
		(line_cfg_reg[3].src == SRC_EXPO && !line_cfg_reg[3].invert) |=>
			line_o[3] == $past(flags_i.expo);
	endproperty
	a_expo_line: assert property (p_expo_line) else $error("exposure not on line");

	property p_tick_rate;
		tick |=> !tick [*8];
	endproperty
	a_tick_rate: assert property (p_tick_rate) else $error("tick too fast");

	property p_ack_once;
		ack_o |=> !ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held twice");

endmodule

// >>> tb/cilt_trig_model.sv
/*
 * bouncing external trigger source that drives the raw input line.
 * assumes the bench sets the settled level on the system clock.
 */
module cilt_trig_model (
	input  wire logic clk_i,
	input  wire logic level_i,
	output logic      line_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       prev_reg = 1'b0;
	logic [3:0] cnt_reg  = 4'h0;
	// contacts chatter for eleven cycles after a change, well under one tick
	always_ff @(posedge clk_i) begin
		prev_reg <= level_i;
		if (prev_reg != level_i) begin
			cnt_reg <= 4'hB;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
		line_o <= (cnt_reg != 4'h0) ? ~line_o : prev_reg;
	end
endmodule

// >>> tb/tb_cilt_camera_io.sv
/*
 * self-checking bench of the camera io block: registers, output sources,
 * input filter and pulse timer.
 * assumes the bouncing trigger model and a 125 MHz clock.
 */
module tb_cilt_camera_io;
	timeunit 1ns;
	timeprecision 1ns;
	import cilt_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, lvl = 1'b0;
	logic [7:0]  adr   = 8'h00;
	logic [3:0]  sel   = 4'h0;
	logic [31:0] dat   = 32'h0, dat_o, q, r, seed = 32'd43545;
	logic        ack, raw;
	logic [5:0]  line_o;
	cilt_flags_t flags = '0;
	int          err_total = 0, num_checks = 0, n;

	cilt_trig_model u_src (.clk_i(clk_i), .level_i(lvl), .line_o(raw));
	cilt_camera_io u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
		.trigger_input_line_i(raw), .flags_i(flags), .line_o(line_o));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial forever #4 clk_i = ~clk_i;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// r[4:0] flags (frame high), r[5] soft level, r[6] invert
	function automatic logic [31:0] exp_line(input logic [2:0] c, input logic [6:0] v);
		logic b;
		b = (c == 3'h1) ? v[4] : (c == 3'h2) ? v[3] : (c == 3'h3) ? v[2] :
			(c == 3'h4) ? v[5] : (c == 3'h6) ? v[1] : 1'b0;
		return {31'h0, b ^ v[6]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp_v);
		num_checks++;
		if (got !== exp_v) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp_v);
		end
	endtask

	// one classic cycle; held until ack is sampled high, then an idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wait_lvl(input logic v, input int lim, output int k);
		k = 0;
		while (line_o[0] !== v && k < lim) begin
			@(posedge clk_i);
			k++;
		end
	endtask

	task automatic test_done();
		if (err_total == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		test_done();
	end

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(0, OFS_LINE_SEL, 0, q); chk(q, 32'h0);
		wb(0, OFS_WIDTH, 0, q); chk(q, 32'h1);
		wb(0, OFS_FILT, 0, q); chk(q, 32'h0);
		wb(0, 8'h40, 0, q); chk(q, 32'h0);
		// every source code on every output line, random flags and invert
		for (int l = 1; l <= 6; l++) begin
			wb(1, OFS_LINE_SEL, l, q);
			wb(0, OFS_LINE_SEL, 0, q); chk(q, 32'h100 | l);
			for (int c = 0; c < 7; c++) begin
				r = xs();
				flags <= cilt_flags_t'(r[4:0]);
				wb(1, OFS_SOFT, {31'h0, r[5]}, q);
				wb(1, OFS_LINE_CFG, {27'h0, r[6], 1'b0, 3'(c)}, q);
				repeat (2) @(posedge clk_i);
				chk({31'h0, line_o[l-1]}, exp_line(3'(c), r[6:0]));
			end
		end
		// filter of two ticks: a short pulse is dropped, a held level lands late
		flags <= '0;
		wb(1, OFS_FILT, 2, q);
		lvl <= 1'b1;
		repeat (100) @(posedge clk_i);
		lvl <= 1'b0;
		repeat (500) @(posedge clk_i);
		wb(0, OFS_STATUS, 0, q); chk(q[0], 0);
		lvl <= 1'b1;
		repeat (230) @(posedge clk_i);
		wb(0, OFS_STATUS, 0, q); chk(q[0], 0);
		repeat (200) @(posedge clk_i);
		wb(0, OFS_STATUS, 0, q); chk(q[0], 1);
		// timer on line one, triggered by the filtered input's falling edge
		wb(1, OFS_LINE_SEL, 1, q);
		wb(1, OFS_LINE_CFG, 5, q);
		wb(1, OFS_TRIG, 32'h13, q);
		lvl <= 1'b0;
		wait_lvl(1, 800, n); chk(n < 800, 1);
		wait_lvl(0, 400, n);
		// rising edges of exposure, frame and counter begin
		for (int k = 0; k < 3; k++) begin
			wb(1, OFS_TRIG, (k == 0) ? 1 : (k == 1) ? 2 : 4, q);
			flags <= cilt_flags_t'(5'h1 << ((k == 0) ? 2 : (k == 1) ? 4 : 0));
			wait_lvl(1, 300, n); chk(n < 300, 1);
			wait_lvl(0, 300, n);
			flags <= '0;
			repeat (3) @(posedge clk_i);
		end
		// delay of three ticks, width of two
		wb(1, OFS_DELAY, 3, q);
		wb(1, OFS_WIDTH, 2, q);
		wb(1, OFS_TRIG, 1, q);
		flags <= 5'h04;
		wait_lvl(1, 700, n); chk(n >= 245 && n <= 505, 1);
		wait_lvl(0, 700, n); chk(n >= 120 && n <= 380, 1);
		flags <= '0;
		// level high with a one tick delay
		wb(1, OFS_DELAY, 1, q);
		wb(1, OFS_TRIG, 32'h21, q);
		repeat (300) @(posedge clk_i);
		chk(line_o[0], 0);
		flags <= 5'h04;
		wait_lvl(1, 400, n); chk(n > 0 && n < 400, 1);
		flags <= '0;
		wait_lvl(0, 4, n); chk(n < 4, 1);
		// restart during the delay: the pulse never comes
		wb(1, OFS_DELAY, 3, q);
		wb(1, OFS_TRIG, 1, q);
		flags <= 5'h04;
		wb(1, OFS_CMD, 1, q);
		wait_lvl(1, 700, n); chk(n, 700);
		// zero filter time: the settled level passes straight through
		wb(1, OFS_FILT, 0, q);
		lvl <= 1'b1;
		repeat (20) @(posedge clk_i);
		wb(0, OFS_STATUS, 0, q); chk(q[0], 1);
		test_done();
	end
endmodule
